// ---- rtl/scw_top.sv ----
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "scw_map.svh"
module scw_top #(
   parameter int ADDR_W = 4                          // Register address width
) (
   input  wire logic                    aclk,        // 200 MHz clock
   input  wire logic                    aresetn,     // Sync reset, active low
   input  wire logic [ADDR_W-1:0]       awaddr,      // Write address
   input  wire logic [2:0]              awprot,      // Unused protection
   input  wire logic                    awvalid,     // Write address valid
   output logic                         awready,     // Write address ready
   input  wire logic [31:0]             wdata,       // Write data
   input  wire logic [3:0]              wstrb,       // Write strobes
   input  wire logic                    wvalid,      // Write data valid
   output logic                         wready,      // Write data ready
   output scw_pkg::scw_resp_t           bresp,       // Write response
   output logic                         bvalid,      // Write response valid
   input  wire logic                    bready,      // Write response ready
   input  wire logic [ADDR_W-1:0]       araddr,      // Read address
   input  wire logic [2:0]              arprot,      // Unused protection
   input  wire logic                    arvalid,     // Read address valid
   output logic                         arready,     // Read address ready
   output logic [31:0]                  rdata,       // Read data
   output scw_pkg::scw_resp_t           rresp,       // Read response
   output logic                         rvalid,      // Read data valid
   input  wire logic                    rready,      // Read data ready
   input  wire logic                    nmi_pin,     // NMI input
   output logic                         nmi_request, // NMI request pulse
   input  wire logic                    cpu_access,  // CPU access strobe
   input  wire scw_pkg::scw_cpu_addr_t  cpu_addr,    // CPU address low bits
   output logic                         sel_byte_timer, // Timer windows
   output logic                         sel_host_kbd,   // Host windows
   output logic [2:0]                   sel_serial,     // Serial ports 0,1,2
   output logic [2:0]                   sel_alt,        // Two-wire 0/1, PWM
   output logic                         ram_enable,     // On-chip RAM enable
   output logic [3:0]                   porta_bus_drive, // Port A 7-4 buffers
   input  wire logic [2:0]              twowire_clock_select, // Mode reg clocks
   output logic [4:0]                   twowire_rate_code     // Master rate code
);
   localparam logic [ADDR_W-1:0] SYS_ADDR = ADDR_W'(`SCW_OFF_SYSCTRL);
   localparam logic [ADDR_W-1:0] ST_ADDR  = ADDR_W'(`SCW_OFF_STCTL);

   // Control bits
   logic       nmi_edge_polarity_reg;
   logic       host_window_select_reg;
   logic       ram_on_reg;
   logic       extra_buffer_select_reg;
   logic [1:0] rate_select_reg;
   logic       twowire_window_select_reg;

   // Write channel state
   logic [ADDR_W-1:0]  aw_addr_reg;
   logic               aw_have_reg;
   logic               aw_have_next;
   scw_pkg::scw_byte_t w_data_reg;
   logic               w_lane_reg;
   logic               w_have_reg;
   logic               w_have_next;
   logic               bvalid_reg;
   logic               bvalid_next;
   scw_pkg::scw_resp_t bresp_reg;

   // Read channel state
   scw_pkg::scw_rd_state_e rd_state_reg;
   scw_pkg::scw_rd_state_e rd_state_next;
   logic [31:0]            rdata_reg;
   scw_pkg::scw_resp_t     rresp_reg;

   // Handshake and decode wires
   logic               aw_hs;
   logic               w_hs;
   logic               ar_hs;
   logic               wr_fire;
   logic               wr_sys;
   logic               wr_st;
   logic               wr_hit;
   logic               rd_sys;
   logic               rd_st;
   scw_pkg::scw_byte_t sys_val;
   scw_pkg::scw_byte_t st_val;
   scw_pkg::scw_byte_t rd_byte;

   // Channel handshakes
   assign awready = ~aw_have_reg & ~bvalid_reg;
   assign wready  = ~w_have_reg & ~bvalid_reg;
   assign aw_hs   = awvalid & awready;
   assign w_hs    = wvalid & wready;
   assign wr_fire = aw_have_reg & w_have_reg & ~bvalid_reg;
   assign arready = (rd_state_reg == scw_pkg::SCW_RD_IDLE);
   assign ar_hs   = arvalid & arready;

   // Write address decode
   assign wr_sys = (aw_addr_reg[ADDR_W-1:2] == SYS_ADDR[ADDR_W-1:2]);
   assign wr_st  = (aw_addr_reg[ADDR_W-1:2] == ST_ADDR[ADDR_W-1:2]);
   assign wr_hit = wr_sys | wr_st;

   // Read address decode
   assign rd_sys = (araddr[ADDR_W-1:2] == SYS_ADDR[ADDR_W-1:2]);
   assign rd_st  = (araddr[ADDR_W-1:2] == ST_ADDR[ADDR_W-1:2]);

   // Register images, unheld bits read zero
   assign sys_val = {5'h00, nmi_edge_polarity_reg, host_window_select_reg, ram_on_reg};
   assign st_val  = {extra_buffer_select_reg, rate_select_reg,
                     twowire_window_select_reg, 4'h0};
   assign rd_byte = rd_sys ? sys_val : (rd_st ? st_val : 8'h00);

   // Next-state terms
   assign aw_have_next  = aw_hs | (aw_have_reg & ~wr_fire);
   assign w_have_next   = w_hs | (w_have_reg & ~wr_fire);
   assign bvalid_next   = wr_fire | (bvalid_reg & ~bready);
   assign rd_state_next = ar_hs ? scw_pkg::SCW_RD_VALID :
                          ((rvalid && rready) ? scw_pkg::SCW_RD_IDLE : rd_state_reg);

   // Write channel capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_addr_reg <= '0;
         aw_have_reg <= 1'b0;
         w_data_reg  <= 8'h00;
         w_lane_reg  <= 1'b0;
         w_have_reg  <= 1'b0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= `SCW_RESP_OKAY;
      end else begin
         if (aw_hs) begin
            aw_addr_reg <= awaddr;
         end
         if (w_hs) begin
            w_data_reg <= wdata[7:0];
            w_lane_reg <= wstrb[0];
         end
         aw_have_reg <= aw_have_next;
         w_have_reg  <= w_have_next;
         bvalid_reg  <= bvalid_next;
         if (wr_fire) begin
            bresp_reg <= wr_hit ? `SCW_RESP_OKAY : `SCW_RESP_SLVERR;
         end
      end
   end

   // System control bits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         nmi_edge_polarity_reg  <= `SCW_RST_NMIPOL;
         host_window_select_reg <= `SCW_RST_HOSTWIN;
         ram_on_reg             <= `SCW_RST_RAMON;
      end else if (wr_fire && wr_sys && w_lane_reg) begin
         nmi_edge_polarity_reg  <= w_data_reg[`SCW_SYS_NMIPOL_BIT];
         host_window_select_reg <= w_data_reg[`SCW_SYS_HOSTWIN_BIT];
         ram_on_reg             <= w_data_reg[`SCW_SYS_RAMON_BIT];
      end
   end

   // Serial timer control bits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         extra_buffer_select_reg   <= `SCW_RST_XBUF;
         rate_select_reg           <= `SCW_RST_RATE;
         twowire_window_select_reg <= `SCW_RST_TWWIN;
      end else if (wr_fire && wr_st && w_lane_reg) begin
         extra_buffer_select_reg   <= w_data_reg[`SCW_ST_XBUF_BIT];
         rate_select_reg           <= {w_data_reg[`SCW_ST_RATEHI_BIT],
                                       w_data_reg[`SCW_ST_RATELO_BIT]};
         twowire_window_select_reg <= w_data_reg[`SCW_ST_TWWIN_BIT];
      end
   end

   // Read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state_reg <= scw_pkg::SCW_RD_IDLE;
         rdata_reg    <= 32'h0000_0000;
         rresp_reg    <= `SCW_RESP_OKAY;
      end else begin
         rd_state_reg <= rd_state_next;
         if (ar_hs) begin
            rdata_reg <= {24'h000000, rd_byte};
            rresp_reg <= (rd_sys | rd_st) ? `SCW_RESP_OKAY : `SCW_RESP_SLVERR;
         end
      end
   end

   // Bus outputs
   assign bvalid = bvalid_reg;
   assign bresp  = bresp_reg;
   assign rvalid = (rd_state_reg == scw_pkg::SCW_RD_VALID);
   assign rdata  = rdata_reg;
   assign rresp  = rresp_reg;

   // Function outputs
   assign ram_enable        = ram_on_reg;
   assign porta_bus_drive   = {4{extra_buffer_select_reg}};
   assign twowire_rate_code = {rate_select_reg, twowire_clock_select};

   // NMI edge detector
   scw_nmi_edge u_nmi (
      .aclk              (aclk),
      .aresetn           (aresetn),
      .nmi_pin           (nmi_pin),
      .nmi_edge_polarity (nmi_edge_polarity_reg),
      .nmi_request       (nmi_request)
   );

   // CPU window decoder
   scw_window_decode u_dec (
      .cpu_access         (cpu_access),
      .cpu_addr           (cpu_addr),
      .host_window_select (host_window_select_reg),
      .twowire_sel        (twowire_window_select_reg),
      .sel_byte_timer     (sel_byte_timer),
      .sel_host_kbd       (sel_host_kbd),
      .sel_serial         (sel_serial),
      .sel_alt            (sel_alt)
   );

   // Edge request follows selected polarity
   nmi_fall_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      ($past(aresetn) && !nmi_edge_polarity_reg && $fell(nmi_pin) &&
       $stable(nmi_edge_polarity_reg))
      |=> nmi_request)
      else $error("falling edge gave no request");

   nmi_rise_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      nmi_request |-> ($past(nmi_edge_polarity_reg) ?
                       ($past(nmi_pin) && !$past(nmi_pin, 2)) :
                       (!$past(nmi_pin) && $past(nmi_pin, 2))))
      else $error("request without matching edge");

   // Host windows
   timer_win_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (cpu_access && cpu_addr == 16'hfff4 && !host_window_select_reg)
      |-> (sel_byte_timer && !sel_host_kbd))
      else $error("timer window not selected");

   host_win_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (cpu_access && cpu_addr == 16'hfffe && host_window_select_reg)
      |-> (sel_host_kbd && !sel_byte_timer))
      else $error("host window not selected");

   // RAM enable after reset
   ram_reset_a: assert property (
      @(posedge aclk) $rose(aresetn) |-> ram_enable)
      else $error("RAM enable not set after reset");

   ram_write_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (wr_fire && wr_sys && w_lane_reg)
      |=> (ram_enable == $past(w_data_reg[`SCW_SYS_RAMON_BIT])))
      else $error("RAM enable did not follow write");

   // RAM enable only moves on a system control write
   ram_hold_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      !(wr_fire && wr_sys && w_lane_reg) |=> $stable(ram_enable))
      else $error("RAM enable changed without write");

   buffer_write_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (wr_fire && wr_st && w_lane_reg && w_data_reg[`SCW_ST_XBUF_BIT])
      |=> (porta_bus_drive == 4'hf))
      else $error("port A buffers not enabled");

   // Buffer and rate levels only move on a serial timer write
   buffer_hold_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      !(wr_fire && wr_st && w_lane_reg)
      |=> ($stable(porta_bus_drive) && $stable(twowire_rate_code[4:3])))
      else $error("buffer or rate bits changed without write");

   rate_write_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (wr_fire && wr_st && w_lane_reg)
      |=> (twowire_rate_code[4:3] == $past(w_data_reg[6:5])))
      else $error("rate field did not follow write");

   serial_win_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (cpu_access && cpu_addr == 16'hff8f && !twowire_window_select_reg)
      |-> (sel_serial == 3'h2 && sel_alt == 3'h0))
      else $error("serial port one window missed");

   tw_one_win_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (cpu_access && cpu_addr == 16'hff88 && twowire_window_select_reg)
      |-> (sel_alt == 3'h2 && sel_serial == 3'h0))
      else $error("two-wire channel one window missed");

   pwm_win_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (cpu_access && cpu_addr == 16'hffa6 && twowire_window_select_reg)
      |-> (sel_alt == 3'h4))
      else $error("PWM window missed");

   tw_zero_win_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (cpu_access && cpu_addr == 16'hffd9 && twowire_window_select_reg)
      |-> (sel_alt == 3'h1))
      else $error("two-wire channel zero window missed");

   reset_clear_a: assert property (
      @(posedge aclk) !aresetn |=> (st_val == 8'h00 && sys_val == 8'h01))
      else $error("select bits not cleared by reset");
endmodule : scw_top
`default_nettype wire

// ---- rtl/scw_map.svh ----
// Operation
// - NMI request on falling edge when polarity bit is 0, rising when 1.
// - Host window bit 0 routes FFF0-FFF7 and FFFC-FFFF to byte timers.
// - Host window bit 1 routes those windows to host and keyboard registers.
// - RAM enable bit returns to 1 when reset is released.
// - On-chip RAM disabled while RAM enable is 0, enabled while 1.
// - Extra buffer bit 1 gives port A pins 7-4 bus-driving buffers.
// - Two-bit rate field in bits 6 and 5 joins clock select for rate.
// - Two-wire window bit 0 maps serial ports 1, 2 and 0 windows.
// - Two-wire window bit 1 maps two-wire channel one at FF88 windows.
// - Two-wire window bit 1 maps PWM converter at FFA0 windows.
// - Two-wire window bit 1 maps two-wire channel zero at FFD8 windows.
`ifndef SCW_MAP_SVH
`define SCW_MAP_SVH

// Register byte offsets
`define SCW_OFF_SYSCTRL     4'h0
`define SCW_OFF_STCTL       4'h4

// System control field positions
`define SCW_SYS_NMIPOL_BIT  2
`define SCW_SYS_HOSTWIN_BIT 1
`define SCW_SYS_RAMON_BIT   0

// Serial timer control field positions
`define SCW_ST_XBUF_BIT     7
`define SCW_ST_RATEHI_BIT   6
`define SCW_ST_RATELO_BIT   5
`define SCW_ST_TWWIN_BIT    4

// Reset values
`define SCW_RST_NMIPOL      1'b0
`define SCW_RST_HOSTWIN     1'b0
`define SCW_RST_RAMON       1'b1
`define SCW_RST_XBUF        1'b0
`define SCW_RST_RATE        2'h0
`define SCW_RST_TWWIN       1'b0

// CPU window bases, low 16 address bits
`define SCW_WIN_HOST_LO     16'hfff0
`define SCW_WIN_HOST_HI     16'hfffc
`define SCW_WIN_SER0        16'hffd8
`define SCW_WIN_SER1        16'hff88
`define SCW_WIN_SER2        16'hffa0
`define SCW_WIN_PAIR_GAP    16'h0006

// Bus responses
`define SCW_RESP_OKAY       2'h0
`define SCW_RESP_SLVERR     2'h2

`endif

// ---- rtl/scw_pkg.sv ----
package scw_pkg;
   typedef logic [7:0]  scw_byte_t;
   typedef logic [1:0]  scw_resp_t;
   typedef logic [15:0] scw_cpu_addr_t;
   typedef enum logic { SCW_RD_IDLE, SCW_RD_VALID } scw_rd_state_e;
endpackage : scw_pkg

// ---- rtl/scw_nmi_edge.sv ----
`timescale 1ns/1ps
`default_nettype none
module scw_nmi_edge (
   input  wire logic aclk,              // System clock
   input  wire logic aresetn,           // Sync reset, active low
   input  wire logic nmi_pin,           // NMI input level
   input  wire logic nmi_edge_polarity, // 0 falling, 1 rising
   output logic      nmi_request        // One-cycle request pulse
);
   logic nmi_prev_reg;
   logic nmi_request_reg;
   logic rise;
   logic fall;

   // Edge selection by polarity
   assign rise = nmi_pin & ~nmi_prev_reg;
   assign fall = ~nmi_pin & nmi_prev_reg;

   // Previous level and request pulse
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         nmi_prev_reg    <= 1'b0;
         nmi_request_reg <= 1'b0;
      end else begin
         nmi_prev_reg    <= nmi_pin;
         nmi_request_reg <= nmi_edge_polarity ? rise : fall;
      end
   end

   assign nmi_request = nmi_request_reg;
endmodule : scw_nmi_edge
`default_nettype wire

// ---- rtl/scw_window_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "scw_map.svh"
module scw_window_decode (
   input  wire logic                  cpu_access,        // CPU access strobe
   input  wire scw_pkg::scw_cpu_addr_t cpu_addr,         // Low 16 address bits
   input  wire logic                  host_window_select, // Host window bit
   input  wire logic                  twowire_sel,       // Two-wire window bit
   output logic                       sel_byte_timer,    // Timer and connection regs
   output logic                       sel_host_kbd,      // Host and keyboard regs
   output logic [2:0]                 sel_serial,        // Serial ports 0,1,2
   output logic [2:0]                 sel_alt            // Two-wire 0, two-wire 1, PWM
);
   localparam logic [15:0] BASES [3] = '{`SCW_WIN_SER0, `SCW_WIN_SER1, `SCW_WIN_SER2};
   logic host_hit;

   // Host windows FFF0-FFF7 and FFFC-FFFF
   assign host_hit = cpu_access &
                     ((cpu_addr[15:3] == `SCW_WIN_HOST_LO >> 3) ||
                      (cpu_addr[15:2] == `SCW_WIN_HOST_HI >> 2));
   assign sel_byte_timer = host_hit & ~host_window_select;
   assign sel_host_kbd   = host_hit & host_window_select;

   // Paired two-byte windows per serial slot
   genvar i;
   generate
      for (i = 0; i < 3; i = i + 1) begin : g_win
         logic [15:0] hi_base;
         logic        hit;
         assign hi_base = BASES[i] + `SCW_WIN_PAIR_GAP;
         assign hit = cpu_access &
                      ((cpu_addr[15:1] == BASES[i][15:1]) ||
                       (cpu_addr[15:1] == hi_base[15:1]));
         assign sel_serial[i] = hit & ~twowire_sel;
         assign sel_alt[i]    = hit & twowire_sel;
      end
   endgenerate
endmodule : scw_window_decode
`default_nettype wire

// ---- verification/sys_ctrl_window_select_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module sys_ctrl_window_select_bench;
   logic                   aclk, aresetn;
   logic [3:0]             awaddr, araddr, wstrb;
   logic [2:0]             awprot, arprot, sel_serial, sel_alt, twowire_clock_select;
   logic                   awvalid, awready, wvalid, wready, bvalid, bready;
   logic                   arvalid, arready, rvalid, rready, nmi_pin, nmi_request;
   logic [31:0]            wdata, rdata;
   scw_pkg::scw_resp_t     bresp, rresp;
   logic                   cpu_access, sel_byte_timer, sel_host_kbd, ram_enable;
   scw_pkg::scw_cpu_addr_t cpu_addr;
   logic [3:0]             porta_bus_drive;
   logic [4:0]             twowire_rate_code;
   // Bench copy of the register bits
   logic                   pol, host, ram, xbuf, tw, prev_pin;
   logic [1:0]             rate;
   int                     fails = 0;
   int                     cmp_count = 0;
   int                     cycles = 0;
   logic [33:0]            rd_q[$];
   scw_pkg::scw_resp_t     wr_q[$];
   logic [17:0]            win_q[$];
   logic                   nmi_q[$];
   logic [15:0]            addrs [23] = '{16'hfff0, 16'hfff7, 16'hfff8, 16'hfffb, 16'hfffc,
      16'hffff, 16'hff88, 16'hff89, 16'hff8a, 16'hff8e, 16'hff8f, 16'hffa0, 16'hffa2,
      16'hffa7, 16'hffd8, 16'hffd9, 16'hffdd, 16'hffde, 16'hffdf, 16'h1234, 16'hfff4,
      16'hfffe, 16'hffa6};

   scw_top #(.ADDR_W(4)) i_scw_top (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .nmi_pin(nmi_pin), .nmi_request(nmi_request),
      .cpu_access(cpu_access), .cpu_addr(cpu_addr), .sel_byte_timer(sel_byte_timer),
      .sel_host_kbd(sel_host_kbd), .sel_serial(sel_serial), .sel_alt(sel_alt),
      .ram_enable(ram_enable), .porta_bus_drive(porta_bus_drive),
      .twowire_clock_select(twowire_clock_select), .twowire_rate_code(twowire_rate_code));

   // Clock generator, 5 ns period
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   task automatic end_sim();
      if (fails == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : end_sim

   // Hang guard
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails++;
         end_sim();
      end
   end

   task automatic report(input logic [33:0] got, input logic [33:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : report
   task automatic cmp_rd(input logic [33:0] got, input logic [33:0] exp);
      report(got, exp);
   endtask : cmp_rd
   task automatic cmp_wr(input scw_pkg::scw_resp_t got, input scw_pkg::scw_resp_t exp);
      report({32'h0, got}, {32'h0, exp});
   endtask : cmp_wr
   task automatic cmp_win(input logic [17:0] got, input logic [17:0] exp);
      report({16'h0, got}, {16'h0, exp});
   endtask : cmp_win
   task automatic cmp_nmi(input logic got, input logic exp);
      report({33'h0, got}, {33'h0, exp});
   endtask : cmp_nmi

   // Result watcher: oldest note against each result seen
   always @(posedge aclk) begin
      if (rvalid === 1'b1 && rready) cmp_rd({rresp, rdata}, rd_q.pop_front());
      if (bvalid === 1'b1 && bready) cmp_wr(bresp, wr_q.pop_front());
      if (cpu_access) cmp_win({sel_byte_timer, sel_host_kbd, sel_serial, sel_alt, ram_enable,
         porta_bus_drive, twowire_rate_code}, win_q.pop_front());
      if (nmi_request !== 1'b0) cmp_nmi(nmi_request, nmi_q.size() > 0 ? nmi_q.pop_front() : 1'b0);
   end

   function automatic logic in_pair(input logic [15:0] a, input logic [15:0] b);
      return a == b || a == b + 16'h0001 || a == b + 16'h0006 || a == b + 16'h0007;
   endfunction : in_pair

   // Expected decode and level outputs from the bench copy
   function automatic logic [17:0] win_exp(input logic [15:0] a, input logic [2:0] cs);
      logic       hh;
      logic [2:0] hit;
      hh  = (a >= 16'hfff0 && a <= 16'hfff7) || a >= 16'hfffc;
      hit = {in_pair(a, 16'hffa0), in_pair(a, 16'hff88), in_pair(a, 16'hffd8)};
      return {hh & ~host, hh & host, hit & {3{~tw}}, hit & {3{tw}}, ram, {4{xbuf}}, rate, cs};
   endfunction : win_exp

   task automatic win_all();
      logic [2:0] cs;
      foreach (addrs[i]) begin
         cs = 3'($urandom);
         @(posedge aclk);
         cpu_access           <= 1'b1;
         cpu_addr             <= addrs[i];
         twowire_clock_select <= cs;
         win_q.push_back(win_exp(addrs[i], cs));
      end
      @(posedge aclk);
      cpu_access <= 1'b0;
   endtask : win_all

   task automatic axi_wr(input logic [3:0] a, input logic [7:0] d, input logic s,
                         input scw_pkg::scw_resp_t er);
      @(posedge aclk);
      awaddr  <= a;
      awprot  <= 3'($urandom);
      wdata   <= {24'($urandom), d};
      wstrb   <= {3'($urandom), s};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      wr_q.push_back(er);
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [3:0] a, input logic [33:0] e);
      @(posedge aclk);
      araddr  <= a;
      arprot  <= 3'($urandom);
      arvalid <= 1'b1;
      rready  <= 1'b1;
      rd_q.push_back(e);
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
   endtask : axi_rd

   task automatic chk_regs();
      axi_rd(4'h0, {26'h0, 5'h0, pol, host, ram});
      axi_rd(4'h4, {26'h0, xbuf, rate, tw, 4'h0});
   endtask : chk_regs
   task automatic wr_sys(input logic [7:0] d);
      axi_wr(4'h0, d, 1'b1, 2'h0);
      {pol, host, ram} = d[2:0];
   endtask : wr_sys
   task automatic wr_st(input logic [7:0] d);
      axi_wr(4'h4, d, 1'b1, 2'h0);
      {xbuf, rate, tw} = d[7:4];
   endtask : wr_st

   // Pin pattern; a pulse is noted per edge of the chosen polarity
   task automatic nmi_drive(input logic [15:0] pat);
      for (int i = 0; i < 16; i++) begin
         @(posedge aclk);
         nmi_pin <= pat[i];
         if (pat[i] != prev_pin && pat[i] == pol) nmi_q.push_back(1'b1);
         prev_pin = pat[i];
      end
   endtask : nmi_drive

   task automatic reset_model();
      {pol, host, ram, xbuf, rate, tw, prev_pin} = 8'b00100000;
   endtask : reset_model

   // Main sequence
   initial begin
      void'($urandom(65926));
      {aresetn, awaddr, araddr, wstrb, awprot, arprot, awvalid, wvalid, bready} = '0;
      {arvalid, rready, nmi_pin, wdata, cpu_access, cpu_addr, twowire_clock_select} = '0;
      reset_model();
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      chk_regs();
      win_all();
      for (int v = 0; v < 8; v++) begin
         wr_sys(8'(v) | (8'($urandom) & 8'hf8));
         chk_regs();
         win_all();
      end
      for (int v = 0; v < 16; v++) begin
         wr_st({4'(v), 4'($urandom)});
         chk_regs();
         win_all();
      end
      axi_wr(4'h0, 8'h06, 1'b0, 2'h0);
      axi_wr(4'h8, 8'hff, 1'b1, 2'h2);
      axi_wr(4'hc, 8'hff, 1'b1, 2'h2);
      axi_rd(4'h8, {2'h2, 32'h0});
      axi_rd(4'hc, {2'h2, 32'h0});
      chk_regs();
      for (int p = 0; p < 2; p++) begin
         wr_sys({5'h0, 1'(p), 2'b01});
         repeat (4) nmi_drive(16'($urandom) & 16'h7fff);
      end
      wr_sys(8'h06);
      wr_st(8'hf0);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      reset_model();
      chk_regs();
      win_all();
      repeat (4) @(posedge aclk);
      cmp_nmi(nmi_q.size() == 0, 1'b1);
      end_sim();
   end
endmodule : sys_ctrl_window_select_bench
`default_nettype wire
